// ===== src/rfrc_pkg.sv
// Constants for the rail fault reaction configuration block
package rfrc_pkg;
    localparam int RFRC_FRAME_W = 16;
    // Command prefixes in frame bits 15:9
    localparam logic [6:0] RFRC_CMD_SUPV1 = 7'h61;
    localparam logic [6:0] RFRC_CMD_FSSM1 = 7'h64;
    // Read of the hardware report, bits 15:8
    localparam logic [7:0] RFRC_CMD_HWCFG = 8'h10;
    localparam int RFRC_PARITY_BIT = 8;
    localparam int RFRC_CORE_HI = 7;
    localparam int RFRC_CORE_LO = 6;
    localparam int RFRC_ANA_HI = 5;
    localparam int RFRC_ANA_LO = 4;
    localparam int RFRC_IO1_BIT = 7;
    localparam int RFRC_LEVEL_BIT = 4;
    localparam logic [1:0] RFRC_REACT_NONE = 2'h0;
    localparam logic [1:0] RFRC_REACT_OV_BOTH_UV_RST = 2'h1;
    localparam logic [1:0] RFRC_REACT_OV_ONLY = 2'h2;
    localparam logic [1:0] RFRC_REACT_ALL = 2'h3;
    localparam logic [1:0] RFRC_CORE_RESET = RFRC_REACT_ALL;
    localparam logic [1:0] RFRC_ANA_RESET = RFRC_REACT_ALL;
    localparam logic [3:0] RFRC_FSSM1_RESET = 4'h0;
    localparam logic [15:0] RFRC_HWCFG_CONST = 16'h0004;
    localparam int RFRC_BITCNT_RESET = 0;
    // Strap tracked until this many sys_clk edges after reset
    localparam logic [1:0] RFRC_LEVEL_SETTLE = 2'h3;
endpackage

// ===== src/rfrc_top.sv
// Fault reaction config registers, SPI slave and fail-safe output mapping
//
// What this block does
// - Core reaction 00: core faults ignored
// - Core 01: OV both outputs, UV reset
// - Core 10: OV both outputs, UV ignored
// - Core 11: OV and UV both outputs
// - Core reaction field resets to 11
// - Analog reaction field resets to 11
// - Analog reaction 00: analog faults ignored
// - Analog 01: OV both outputs, UV reset
// - Analog 10: OV both, UV ignored
// - Analog 11: OV and UV both outputs
// - Reset and fail-safe outputs active low
// - Enabled drift over 100mV forces safe state
// - IO1 safety enable, resets to non-safety
// - Supervisor frame fields, echoed in reply
// - Report analog rail level in bit4
// - Enabled analog faults pull their mapped outputs low only while present
`timescale 1ns/100ps
module rfrc_top
    import rfrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic core_ov,
    input wire logic core_uv,
    input wire logic analog_ov,
    input wire logic analog_uv,
    input wire logic io1_drift,
    input wire logic analog_rail_level_pin,
    input wire logic init_phase,
    output logic reset_out_n,
    output logic failsafe_out_n
);
    // Link side: shift register on spi_sclk, frame ends on the 16th spi_sclk edge
    logic [15:0] rx_shift;
    logic [15:0] next_rx_shift;
    logic [15:0] tx_shift;
    logic [15:0] next_tx_shift;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [15:0] frame_hold;
    logic [15:0] next_frame_hold;
    logic frame_tgl;
    logic next_frame_tgl;
    // Reply word, stable in sys_clk domain between frames
    logic [15:0] reply;

    always_comb begin
        next_rx_shift = {rx_shift[14:0], spi_mosi};
        next_bit_cnt = bit_cnt;
        next_frame_hold = frame_hold;
        next_frame_tgl = frame_tgl;
        next_tx_shift = {tx_shift[14:0], 1'b0};
        if (bit_cnt == 5'd0) begin
            // Reply loaded at first edge; quasi-static, changes only after
            // a completed frame is processed
            next_tx_shift = {reply[14:0], 1'b0};
        end
        if (bit_cnt != 5'd16) begin
            next_bit_cnt = bit_cnt + 5'd1;
        end
        if (bit_cnt == 5'd15) begin
            next_frame_hold = next_rx_shift;
            next_frame_tgl = ~frame_tgl;
        end
    end

    // Counter cleared by chip select so nothing waits on a stopped clock
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt <= 5'd0;
        end else begin
            bit_cnt <= next_bit_cnt;
        end
    end

    always_ff @(posedge spi_sclk or negedge resetn) begin
        if (!resetn) begin
            rx_shift <= 16'h0000;
            tx_shift <= 16'h0000;
            frame_hold <= 16'h0000;
            frame_tgl <= 1'b0;
        end else begin
            rx_shift <= next_rx_shift;
            tx_shift <= next_tx_shift;
            frame_hold <= next_frame_hold;
            frame_tgl <= next_frame_tgl;
        end
    end

    // Reply only moves between frames, so the link reads it without a sync
    assign spi_miso = (bit_cnt == 5'd0) ? reply[15] : tx_shift[15];

    // System side state
    logic tgl_s;
    logic tgl_seen;
    logic next_tgl_seen;
    logic [1:0] core_fault_reaction_sel;
    logic [1:0] next_core_sel;
    logic [1:0] analog_rail_fault_reaction_sel;
    logic [1:0] next_ana_sel;
    logic [3:0] fssm1_field;
    logic [3:0] next_fssm1_field;
    logic [15:0] next_reply;
    logic [5:0] in_s2;
    logic [1:0] level_wait;
    logic [1:0] next_level_wait;
    logic analog_rail_level_report;
    logic next_level_report;
    logic rst_n_q;
    logic next_rst_n_q;
    logic fs_n_q;
    logic next_fs_n_q;
    logic [15:0] fr;
    logic frame_new;
    logic parity_ok;
    logic core_rst;
    logic core_fs;
    logic ana_rst;
    logic ana_fs;
    logic io1_safety_input_en;
    logic drift_flt;

    // Pins pass two flops; they are not timed to sys_clk
    rfrc_sync2 #(
        .W(6)
    ) u_pin_sync (
        .clk(sys_clk),
        .rst_n(resetn),
        .d({analog_rail_level_pin, io1_drift, analog_uv, analog_ov,
            core_uv, core_ov}),
        .q(in_s2)
    );

    // Frame toggle crosses from the link clock; its edge marks a frame
    rfrc_sync2 #(
        .W(1)
    ) u_tgl_sync (
        .clk(sys_clk),
        .rst_n(resetn),
        .d(frame_tgl),
        .q(tgl_s)
    );

    assign io1_safety_input_en = fssm1_field[3];
    assign fr = frame_hold;
    assign frame_new = tgl_seen ^ tgl_s;
    // Odd parity over the whole frame; secure bits left to software
    assign parity_ok = ^fr;
    assign drift_flt = io1_safety_input_en & in_s2[4];

    // Same mapping for both rails: 00 none, 01 OV both UV reset, 10 OV both
    rfrc_react_map u_core_map (
        .sel(core_fault_reaction_sel),
        .ov(in_s2[0]),
        .uv(in_s2[1]),
        .rst_req(core_rst),
        .fs_req(core_fs)
    );

    rfrc_react_map u_ana_map (
        .sel(analog_rail_fault_reaction_sel),
        .ov(in_s2[2]),
        .uv(in_s2[3]),
        .rst_req(ana_rst),
        .fs_req(ana_fs)
    );

    always_comb begin
        next_tgl_seen = tgl_s;
        next_core_sel = core_fault_reaction_sel;
        next_ana_sel = analog_rail_fault_reaction_sel;
        next_fssm1_field = fssm1_field;
        next_reply = reply;
        next_level_wait = level_wait;
        next_level_report = analog_rail_level_report;
        if (level_wait != RFRC_LEVEL_SETTLE) begin
            // Strap followed until the synchroniser holds the real pin level
            next_level_wait = level_wait + 2'h1;
            next_level_report = in_s2[5];
        end
        if (frame_new) begin
            if (fr[15:9] == RFRC_CMD_SUPV1) begin
                if (parity_ok && init_phase) begin
                    next_core_sel = fr[RFRC_CORE_HI:RFRC_CORE_LO];
                    next_ana_sel = fr[RFRC_ANA_HI:RFRC_ANA_LO];
                end
                next_reply = {8'h00, 4'h0, next_core_sel, next_ana_sel};
            end else if (fr[15:9] == RFRC_CMD_FSSM1) begin
                if (parity_ok && init_phase) begin
                    next_fssm1_field = fr[RFRC_IO1_BIT:4];
                end
                next_reply = {12'h000, next_fssm1_field};
            end else if (fr[15:8] == RFRC_CMD_HWCFG) begin
                next_reply = RFRC_HWCFG_CONST;
                next_reply[RFRC_LEVEL_BIT] = analog_rail_level_report;
            end else begin
                next_reply = 16'h0000;
            end
        end
        // Safe state held while any enabled fault persists; no latching
        next_rst_n_q = ~(core_rst | ana_rst | drift_flt);
        next_fs_n_q = ~(core_fs | ana_fs | drift_flt);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tgl_seen <= 1'b0;
            core_fault_reaction_sel <= RFRC_CORE_RESET;
            analog_rail_fault_reaction_sel <= RFRC_ANA_RESET;
            fssm1_field <= RFRC_FSSM1_RESET;
            reply <= 16'h0000;
            level_wait <= 2'h0;
            analog_rail_level_report <= 1'b0;
            rst_n_q <= 1'b0;
            fs_n_q <= 1'b0;
        end else begin
            tgl_seen <= next_tgl_seen;
            core_fault_reaction_sel <= next_core_sel;
            analog_rail_fault_reaction_sel <= next_ana_sel;
            fssm1_field <= next_fssm1_field;
            reply <= next_reply;
            level_wait <= next_level_wait;
            analog_rail_level_report <= next_level_report;
            rst_n_q <= next_rst_n_q;
            fs_n_q <= next_fs_n_q;
        end
    end

    assign reset_out_n = rst_n_q;
    assign failsafe_out_n = fs_n_q;
endmodule

// Two-flop synchroniser; only the second stage leaves this module
module rfrc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule

// One rail's OV and UV mapped onto reset and fail-safe requests
module rfrc_react_map
    import rfrc_pkg::*;
(
    input wire logic [1:0] sel,
    input wire logic ov,
    input wire logic uv,
    output logic rst_req,
    output logic fs_req
);
    // OV reaches fail-safe in every unmasked setting; UV only in 11
    always_comb begin
        rst_req = 1'b0;
        fs_req = 1'b0;
        case (sel)
            RFRC_REACT_NONE: begin
                rst_req = 1'b0;
            end
            RFRC_REACT_OV_BOTH_UV_RST: begin
                rst_req = ov | uv;
                fs_req = ov;
            end
            RFRC_REACT_OV_ONLY: begin
                rst_req = ov;
                fs_req = ov;
            end
            default: begin
                rst_req = ov | uv;
                fs_req = rst_req;
            end
        endcase
    end
endmodule

// ===== tb/rfrc_assertions.sv
// Checker for the fail-safe output mapping, bound to rfrc_top
`timescale 1ns/100ps
module rfrc_assertions (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    input wire logic core_ov,
    input wire logic core_uv,
    input wire logic analog_ov,
    input wire logic analog_uv,
    input wire logic io1_drift,
    input wire logic analog_rail_level_pin,
    input wire logic init_phase,
    input wire logic reset_out_n,
    input wire logic failsafe_out_n
);
    logic [5:0] hist;
    logic [2:0] up;
    logic dflt;
    logic any_flt;
    assign any_flt = core_ov | core_uv | analog_ov | analog_uv | io1_drift;
    // History spans the sync latency with margin
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hist <= 6'h00;
            up <= 3'h0;
            dflt <= 1'b1;
        end else begin
            hist <= {hist[4:0], any_flt};
            up <= (up == 3'h7) ? up : up + 3'h1;
            dflt <= dflt & spi_cs_n;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence quiet_s;
        up == 3'h7 && hist == 6'h00;
    endsequence
    sequence uv_held_s;
        (dflt && up == 3'h7 && core_uv) [*4];
    endsequence
    a_idle_rst_high: assert property (quiet_s |-> reset_out_n)
        else $error("reset output low with no fault");
    a_idle_fs_high: assert property (quiet_s |-> failsafe_out_n)
        else $error("fail-safe output low with no fault");
    a_fs_with_rst: assert property (!failsafe_out_n |-> !reset_out_n)
        else $error("fail-safe low while reset high");
    a_rst_low_cause: assert property (
        up == 3'h7 && !reset_out_n |-> |hist)
        else $error("reset output low without cause");
    a_fs_low_cause: assert property (
        up == 3'h7 && !failsafe_out_n |-> |hist)
        else $error("fail-safe output low without cause");
    a_rst_change_cause: assert property (
        up == 3'h7 && !$stable(reset_out_n) |-> hist != 6'h00)
        else $error("reset output moved without cause");
    a_fs_change_cause: assert property (
        up == 3'h7 && !$stable(failsafe_out_n) |-> hist != 6'h00)
        else $error("fail-safe output moved without cause");
    a_default_react: assert property (
        uv_held_s |=> !failsafe_out_n && !reset_out_n)
        else $error("default reaction missing on core undervoltage");
endmodule
bind rfrc_top rfrc_assertions u_chk (.sys_clk, .resetn, .spi_sclk,
    .spi_cs_n, .spi_mosi, .spi_miso, .core_ov, .core_uv, .analog_ov,
    .analog_uv, .io1_drift, .analog_rail_level_pin, .init_phase,
    .reset_out_n, .failsafe_out_n);

// ===== tb/rfrc_host.sv
// Host microcontroller model issuing 16-bit SPI frames
`timescale 1ns/100ps
module rfrc_host (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Odd parity in bit8 unless a corrupt frame is wanted
    task automatic send(input logic [6:0] cmd, input logic [7:0] fld,
                        input logic bad, output logic [15:0] rx);
        logic [15:0] tx;
        tx = {cmd, ~(^{cmd, fld}) ^ bad, fld};
        // Offset keeps link edges clear of sys_clk edges when send starts on a sys_clk edge, not right after another send
        #1;
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = tx[i];
            #80 rx[i] = spi_miso;
            spi_sclk = 1'b1;
            #80 spi_sclk = 1'b0;
        end
        // Released line must not keep showing the last bit
        spi_mosi = ~spi_mosi;
        spi_cs_n = 1'b1;
        #160;
    endtask
endmodule

// ===== tb/rfrc_top_test.sv
// Self-checking bench for the rail fault reaction block
`timescale 1ns/100ps
module rfrc_top_test;
    import rfrc_pkg::*;
    logic sys_clk, resetn, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
    logic init_phase, reset_out_n, failsafe_out_n, level_pin;
    logic [4:0] flt;
    logic [15:0] rx;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    rfrc_top DUT (.sys_clk, .resetn, .spi_sclk, .spi_cs_n, .spi_mosi,
        .spi_miso, .core_ov(flt[4]), .core_uv(flt[3]), .analog_ov(flt[2]),
        .analog_uv(flt[1]), .io1_drift(flt[0]),
        .analog_rail_level_pin(level_pin), .init_phase, .reset_out_n,
        .failsafe_out_n);
    rfrc_host u_host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic print_verdict;
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            print_verdict;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Outputs {reset_n, failsafe_n} for a reaction setting and fault kind
    function automatic logic [1:0] react(input logic [1:0] sel,
                                         input logic uv);
        if (sel == RFRC_REACT_NONE) return 2'b11;
        if (!uv || sel == RFRC_REACT_ALL) return 2'b00;
        return (sel == RFRC_REACT_OV_ONLY) ? 2'b11 : 2'b01;
    endfunction
    task automatic fault(input logic [4:0] v, input logic [1:0] exp);
        @(posedge sys_clk) flt <= v;
        repeat (4) @(posedge sys_clk);
        #1 chk({14'h0, reset_out_n, failsafe_out_n}, {14'h0, exp});
        @(posedge sys_clk) flt <= 5'h00;
        repeat (4) @(posedge sys_clk);
    endtask
    // Reply arrives in the following frame, so fetch it with a read
    task automatic wr(input logic [6:0] cmd, input logic [7:0] f,
                      input logic bad, input logic [3:0] echo);
        u_host.send(cmd, f, bad, rx);
        u_host.send(7'h08, 8'h00, 1'b0, rx);
        chk(rx, {12'h000, echo});
    endtask
    task automatic do_reset;
        @(posedge sys_clk) resetn <= 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask
    initial begin
        resetn = 1'b0;
        flt = 5'h00;
        init_phase = 1'b1;
        level_pin = 1'b0;
        do_reset;
        fault(5'h08, 2'b00);
        fault(5'h02, 2'b00);
        fault(5'h01, 2'b11);
        u_host.send(7'h08, 8'h00, 1'b0, rx);
        u_host.send(7'h08, 8'h00, 1'b0, rx);
        chk(rx, 16'h0004);
        @(posedge sys_clk) init_phase <= 1'b0;
        wr(RFRC_CMD_SUPV1, 8'h00, 1'b0, 4'hf);
        @(posedge sys_clk) init_phase <= 1'b1;
        wr(RFRC_CMD_SUPV1, 8'h00, 1'b1, 4'hf);
        for (int s = 0; s < 4; s++) begin
            logic [1:0] c, a;
            c = s[1:0];
            a = ~c;
            wr(RFRC_CMD_SUPV1, {c, a, 4'h0}, 1'b0, {c, a});
            fault(5'h10, react(c, 1'b0));
            fault(5'h08, react(c, 1'b1));
            fault(5'h04, react(a, 1'b0));
            fault(5'h02, react(a, 1'b1));
        end
        wr(RFRC_CMD_FSSM1, 8'h80, 1'b0, 4'h8);
        fault(5'h01, 2'b00);
        @(posedge sys_clk) level_pin <= 1'b1;
        do_reset;
        fault(5'h01, 2'b11);
        wr(RFRC_CMD_SUPV1, 8'h00, 1'b1, 4'hf);
        u_host.send(7'h08, 8'h00, 1'b0, rx);
        chk(rx, 16'h0014);
        print_verdict;
    end
endmodule
